// File: dv/hms_checker.sv
/*
  Port checker for the monitor interpreter.
  Assumes it is bound to hms_monitor and sees only its ports.
*/
`timescale 1ns/10ps
module hms_checker (
  input wire logic SYS_CLK, // Clock
  input wire logic ARST_N, // Reset, active low
  input wire logic RX_VALID, // Character strobe
  input wire logic [7:0] RX_DATA, // Character
  input wire logic TX_READY, // Host takes byte
  input wire logic TX_VALID, // Byte offered
  input wire logic [7:0] TX_DATA, // Byte offered data
  input wire logic [7:0] LED_PORT, // LEDs
  input wire logic RING_IND, // Ring indicator
  input wire logic NMI_REQ, // Interrupt request
  input wire logic RESET_REQ, // Reset pulse
  input wire logic USER_MAP // User layout
);
  logic acc, echo_q, bs_in, sl_in, esc_in;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);
  // A character counts only when no echo is stalled
  assign acc = RX_VALID && !(TX_VALID && !TX_READY);
  assign bs_in = acc && echo_q && RX_DATA == hms_pkg::CHR_BSLASH;
  assign sl_in = acc && echo_q && RX_DATA == hms_pkg::CHR_SLASH;
  assign esc_in = acc && !echo_q && RX_DATA == hms_pkg::CMD_ESCAPE;
  // Shadow of start-up mode, so checks know echo from commands
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      echo_q <= 1'b1;
    end else if (bs_in || sl_in) begin
      echo_q <= 1'b0;
    end
  end
  sequence s_echo_in;
    acc && echo_q && !bs_in && !sl_in;
  endsequence
  sequence s_start_in;
    acc && !echo_q && RX_DATA == hms_pkg::CMD_START;
  endsequence
  property p_echo;
    s_echo_in |=> TX_VALID && TX_DATA == $past(RX_DATA) + 8'h01;
  endproperty
  a_echo: assert property (p_echo) else $error("echo byte wrong");
  property p_led;
    s_echo_in |=> LED_PORT == $past(RX_DATA);
  endproperty
  a_led: assert property (p_led) else $error("led value wrong");
  property p_user;
    bs_in |=> USER_MAP && !TX_VALID;
  endproperty
  a_user: assert property (p_user) else $error("backslash ignored");
  property p_map_src;
    $rose(USER_MAP) |-> $past(bs_in);
  endproperty
  a_map_src: assert property (p_map_src) else $error("map set early");
  property p_slash;
    sl_in |=> !TX_VALID && !USER_MAP;
  endproperty
  a_slash: assert property (p_slash) else $error("slash handled wrong");
  property p_ring;
    s_start_in |=> RING_IND;
  endproperty
  a_ring: assert property (p_ring) else $error("ring not raised");
  property p_rst;
    RESET_REQ |-> $past(esc_in) ##1 !RESET_REQ;
  endproperty
  a_rst: assert property (p_rst) else $error("reset pulse wrong");
  property p_nmi;
    NMI_REQ == RX_VALID;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi not routed");
  property p_tx_hold;
    TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("echo dropped");
endmodule

bind hms_monitor hms_checker u_chk (.SYS_CLK, .ARST_N, .RX_VALID, .RX_DATA, .TX_READY,
  .TX_VALID, .TX_DATA, .LED_PORT, .RING_IND, .NMI_REQ, .RESET_REQ, .USER_MAP);

// File: dv/hms_host.sv
/*
  Host model: sends characters, takes echoed bytes, polls status.
  Assumes tasks are entered just after a rising clock edge.
*/
`timescale 1ns/10ps
module hms_host (
  input wire logic clk, // Clock
  input wire logic tx_valid, // Byte offered
  input wire logic [7:0] tx_data, // Byte offered data
  input wire logic ring_ind, // Ring indicator
  output logic rx_valid, // Character strobe
  output logic [7:0] rx_data, // Character
  output logic tx_ready // Taking bytes
);
  logic [1:0] tick;
  logic [7:0] got;
  logic slow; // Set by the bench to stall the receiver
  int n_got;
  initial begin
    slow = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b1;
    tick = 2'd0;
    got = 8'h00;
    n_got = 0;
  end
  // Slow mode takes one byte in four cycles
  always @(posedge clk) begin
    tick <= tick + 2'd1;
    tx_ready <= !slow || tick == 2'd2;
    if (tx_valid && tx_ready) begin
      got <= tx_data;
      n_got <= n_got + 1;
    end
  end
  // Held until taken; released data is inverted, not left stale
  task automatic send(input logic [7:0] b);
    rx_valid <= 1'b1;
    rx_data <= b;
    @(posedge clk);
    while (tx_valid && !tx_ready) @(posedge clk);
    rx_valid <= 1'b0;
    rx_data <= ~b;
    @(posedge clk);
  endtask
  task automatic poll();
    while (ring_ind) @(posedge clk);
    send(hms_pkg::CMD_STATUS);
  endtask
endmodule

// File: dv/host_monitor_status_startup_test.sv
/*
  Self-checking bench: echo start-up, command decode, status, escape.
  Assumes the host model and the bound checker.
*/
`timescale 1ns/10ps
module host_monitor_status_startup_test;
  logic clk, arst_n, psel, penable, pwrite, pready, err, perr;
  logic rx_valid, tx_valid, tx_ready, ring, reset_req, user_map, nmi;
  logic [7:0] paddr, rx_data, tx_data, led;
  logic [31:0] pwdata, prdata, rd;
  int num_errors = 0, samples_checked = 0, pulses = 0;
  hms_monitor dut (.SYS_CLK(clk), .ARST_N(arst_n), .RX_VALID(rx_valid), .RX_DATA(rx_data),
    .TX_READY(tx_ready), .TX_VALID(tx_valid), .TX_DATA(tx_data), .LED_PORT(led),
    .RING_IND(ring), .NMI_REQ(nmi), .RESET_REQ(reset_req), .USER_MAP(user_map),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(err));
  hms_host host (.clk(clk), .tx_valid(tx_valid), .tx_data(tx_data), .ring_ind(ring),
    .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready));
  // Mid-cycle sampling avoids racing the launching edge
  always @(negedge clk) if (reset_req === 1'b1) pulses++;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One transfer, then a free cycle so psel never toggles twice
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    perr = err;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic do_reset();
    arst_n <= 1'b0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
  endtask
  task automatic wait_tx(input int n);
    for (int i = 0; i < 40 && host.n_got < n; i++) @(posedge clk);
    chk("tx count", n, host.n_got);
  endtask
  task automatic t_echo();
    do_reset();
    host.send(8'h41);
    wait_tx(1);
    chk("echo", 32'h42, host.got);
    chk("led", 32'h41, led);
    host.send(8'hFF);
    wait_tx(2);
    chk("wrap", 32'h00, host.got);
    host.slow <= 1'b1;
    host.send(8'h10);
    host.send(8'h20);
    wait_tx(4);
    chk("stalled echo", 32'h21, host.got);
    host.slow <= 1'b0;
  endtask
  task automatic t_diag();
    do_reset();
    host.send(hms_pkg::CHR_SLASH);
    host.send(8'h41);
    chk("no echo", 4, host.n_got);
    apb(1'b0, hms_pkg::REG_DATA, 32'h0);
    chk("data", 32'h41, rd);
    apb(1'b0, hms_pkg::REG_FLAGS, 32'h0);
    chk("diag flag", 1, rd[hms_pkg::FLG_DIAG]);
  endtask
  task automatic t_normal();
    do_reset();
    host.send(hms_pkg::CHR_BSLASH);
    chk("user map", 1, user_map);
    for (int i = 0; i < 5; i++) host.send(8'h34 + 8'h22 * i[7:0]);
    apb(1'b0, hms_pkg::REG_DATA, 32'h0);
    chk("shift", 32'h5678_9ABC, rd);
    host.send(hms_pkg::CMD_LITERAL);
    host.send(8'h05);
    apb(1'b0, hms_pkg::REG_DATA, 32'h0);
    chk("literal", 32'h789A_BC05, rd);
    host.poll();
    apb(1'b0, hms_pkg::REG_DATA, 32'h0);
    chk("stopped", 32'h789A_0000, rd);
    host.send(hms_pkg::CMD_START);
    chk("ring on", 1, ring);
    apb(1'b1, hms_pkg::REG_CTRL, 32'h0000_0001);
    chk("ring off", 0, ring);
    host.poll();
    apb(1'b0, hms_pkg::REG_DATA, 32'h0);
    chk("breakpoint", 32'h789A_0002, rd);
    host.send(hms_pkg::CMD_XMIT);
    wait_tx(5);
    chk("xmit", 32'h0000_0002, host.got);
    apb(1'b0, hms_pkg::REG_DATA, 32'h0);
    chk("xmit shift", 32'h0078_9A00, rd);
    host.send(hms_pkg::CMD_START);
    host.send(hms_pkg::CMD_STOP);
    chk("ring stop", 0, ring);
    host.poll();
    apb(1'b0, hms_pkg::REG_DATA, 32'h0);
    chk("stopped after run", 32'h0078_0000, rd);
    host.send(hms_pkg::CMD_START);
    apb(1'b1, hms_pkg::REG_CTRL, 32'h0000_0002);
    chk("ctrl stop", 0, ring);
    apb(1'b1, hms_pkg::REG_DATA, 32'hABCD_0002);
    host.send(hms_pkg::CMD_ESCAPE);
    chk("no reset", 0, pulses);
    apb(1'b1, hms_pkg::REG_DATA, 32'hABCD_0001);
    host.send(hms_pkg::CMD_ESCAPE);
    chk("reset pulse", 1, pulses);
    apb(1'b0, hms_pkg::REG_LAST, 32'h0);
    chk("last char", 32'h0000_0015, rd);
    apb(1'b1, 8'h10, 32'h0);
    chk("unmapped", 1, perr);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    @(posedge clk);
    t_echo();
    t_diag();
    t_normal();
    finish_test();
  end
  // Watchdog at 2000 cycles, well beyond the hundred-odd cycles needed
  initial begin
    #100000;
    num_errors++;
    finish_test();
  end
endmodule

// File: verilog/hms_apb.sv
/*
  APB slave decode for the monitor registers.
  Assumes an APB master; answers with zero wait states, pslverr on
  unmapped offsets.
*/
`timescale 1ns/10ps
module hms_apb (
  input wire hms_pkg::hms_apb_req_t req, // APB request bundle
  input wire logic [31:0] data_val, // Monitor data register
  input wire logic [7:0] flags_val, // Flag register view
  input wire logic [7:0] last_val, // Last received character
  output logic [31:0] prdata, // Read data
  output logic pslverr, // Unmapped access
  output logic wr_data, // Write to data register
  output logic wr_ctrl // Write to control register
);

  // Decode; no wait states so pready is always high at the top
  always_comb begin
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    wr_data = 1'b0;
    wr_ctrl = 1'b0;
    case (req.paddr)
      hms_pkg::REG_DATA: begin
        prdata = data_val;
        wr_data = req.psel && req.penable && req.pwrite;
      end
      hms_pkg::REG_FLAGS: begin
        prdata = {24'h0000_00, flags_val};
      end
      hms_pkg::REG_CTRL: begin
        wr_ctrl = req.psel && req.penable && req.pwrite;
      end
      hms_pkg::REG_LAST: begin
        prdata = {24'h0000_00, last_val};
      end
      default: begin
        pslverr = req.psel && req.penable;
      end
    endcase
  end

endmodule

// File: verilog/hms_classify.sv
/*
  Character classifier for the monitor.
  Assumes a byte and the literal-next flag are valid in the same cycle.
*/
`timescale 1ns/10ps
module hms_classify (
  input wire logic [7:0] ch, // Received character
  input wire logic lit_flag, // Literal-next flag
  output logic is_cmd, // Character is a command
  output logic is_slash, // Forward slash
  output logic is_bslash // Backslash
);

  // Commands are low codes unless literal-next forces data
  always_comb begin
    is_cmd = (ch < hms_pkg::CMD_LIMIT) && !lit_flag;
    is_slash = (ch == hms_pkg::CHR_SLASH);
    is_bslash = (ch == hms_pkg::CHR_BSLASH);
  end

endmodule

// File: verilog/hms_monitor.sv
/*
  Host monitor command interpreter: echo start-up mode, command and data
  decode, status query, extended escape with reset request, ring
  indicator. Assumes a serial receiver hands one byte per strobe and a
  transmitter takes one byte when TX_READY is high.
*/
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/10ps

// Behaviour
// - Breakpoint halt reports status value two
// - Ring indicator follows the running flag
// - Code 0x15 is extended command
// - Escape with low word one resets
// - Reset starts echo, increments and returns
// - Echo mode shows character on LEDs
// - Echo ends only on slash characters
// - Backslash: user map, normal processing
// - Slash: commands with diagnostic flag set
// - Receive strobe drives non-maskable interrupt
// - Status 0x14 reports stopped or running
// - Below 32 is command unless literal-next
// - Data bytes shift into data register
module hms_monitor (
  input wire logic SYS_CLK, // 20 MHz clock
  input wire logic ARST_N, // Async reset, active low
  input wire logic RX_VALID, // Received byte strobe
  input wire logic [7:0] RX_DATA, // Received byte
  input wire logic TX_READY, // Transmitter can accept
  output logic TX_VALID, // Byte to send
  output logic [7:0] TX_DATA, // Byte to send data
  output logic [7:0] LED_PORT, // General-purpose port 1 LEDs
  output logic RING_IND, // Ring-indicator modem status
  output logic NMI_REQ, // Non-maskable interrupt request
  output logic RESET_REQ, // Processor reset request pulse
  output logic USER_MAP, // Memory map is user layout
  input wire logic PSEL, // APB select
  input wire logic PENABLE, // APB enable
  input wire logic PWRITE, // APB direction
  input wire logic [7:0] PADDR, // APB byte address
  input wire logic [31:0] PWDATA, // APB write data
  output logic [31:0] PRDATA, // APB read data
  output logic PREADY, // APB ready
  output logic PSLVERR // APB error
);

  typedef struct packed {
    hms_pkg::hms_mode_t mode;
    logic [31:0] data;
    logic lit;
    logic run;
    logic brk;
    logic umap;
    logic diag;
    logic rst;
    logic tx_valid;
    logic [7:0] tx_data;
    logic [7:0] led;
    logic [7:0] last;
  } hms_state_t;

  hms_state_t s_q;
  hms_state_t s_d;
  hms_pkg::hms_apb_req_t apb_req;
  logic is_cmd;
  logic is_slash;
  logic is_bslash;
  logic wr_data;
  logic wr_ctrl;
  logic [31:0] rd_data;
  logic apb_err;
  logic [7:0] flags_val;
  logic rx_take;
  logic [15:0] status_val;

  assign apb_req = '{psel: PSEL, penable: PENABLE, pwrite: PWRITE, paddr: PADDR,
                     pwdata: PWDATA};

  // Flag view for software
  always_comb begin
    flags_val = 8'h00;
    flags_val[hms_pkg::FLG_LIT] = s_q.lit;
    flags_val[hms_pkg::FLG_BRK] = s_q.brk;
    flags_val[hms_pkg::FLG_RUN] = s_q.run;
    flags_val[hms_pkg::FLG_MAP] = s_q.umap;
    flags_val[hms_pkg::FLG_ECHO] = (s_q.mode == hms_pkg::HMS_ECHO);
    flags_val[hms_pkg::FLG_DIAG] = s_q.diag;
  end

  hms_classify u_cls (
    .ch(RX_DATA),
    .lit_flag(s_q.lit),
    .is_cmd(is_cmd),
    .is_slash(is_slash),
    .is_bslash(is_bslash)
  );

  hms_apb u_apb (
    .req(apb_req),
    .data_val(s_q.data),
    .flags_val(flags_val),
    .last_val(s_q.last),
    .prdata(rd_data),
    .pslverr(apb_err),
    .wr_data(wr_data),
    .wr_ctrl(wr_ctrl)
  );

  // Character is consumed only once the previous reply has left
  assign rx_take = RX_VALID && !(s_q.tx_valid && !TX_READY);

  always_comb begin
    if (s_q.run) begin
      status_val = hms_pkg::STAT_RUNNING;
    end else if (s_q.brk) begin
      status_val = hms_pkg::STAT_BREAK;
    end else begin
      status_val = hms_pkg::STAT_STOPPED;
    end
  end

  // Next-state logic for the whole interpreter
  always_comb begin
    s_d = s_q;
    s_d.rst = 1'b0;
    if (s_q.tx_valid && TX_READY) begin
      s_d.tx_valid = 1'b0;
    end
    // Software writes from the processor side of the monitor
    if (wr_data) begin
      s_d.data = apb_req.pwdata;
    end
    if (wr_ctrl && apb_req.pwdata[hms_pkg::CTL_BREAK]) begin
      s_d.brk = 1'b1;
      s_d.run = 1'b0;
    end
    if (wr_ctrl && apb_req.pwdata[hms_pkg::CTL_STOP]) begin
      s_d.run = 1'b0;
    end
    // Host traffic takes priority over a same-cycle software write
    if (rx_take) begin
      s_d.last = RX_DATA;
      case (s_q.mode)
        hms_pkg::HMS_ECHO: begin
          s_d.led = RX_DATA;
          if (is_bslash) begin
            s_d.mode = hms_pkg::HMS_NORMAL;
            s_d.umap = 1'b1;
          end else if (is_slash) begin
            s_d.mode = hms_pkg::HMS_DIAG;
            s_d.diag = 1'b1;
          end else begin
            s_d.tx_valid = 1'b1;
            s_d.tx_data = RX_DATA + hms_pkg::ECHO_STEP;
          end
        end
        hms_pkg::HMS_NORMAL, hms_pkg::HMS_DIAG: begin
          if (!is_cmd) begin
            s_d.lit = 1'b0;
            s_d.data = {s_q.data[31-hms_pkg::BYTE_W:0], RX_DATA};
          end else begin
            case (RX_DATA)
              hms_pkg::CMD_LITERAL: begin
                s_d.lit = 1'b1;
              end
              hms_pkg::CMD_XMIT: begin
                s_d.tx_valid = 1'b1;
                s_d.tx_data = s_q.data[7:0];
                s_d.data = {8'h00, s_q.data[31:hms_pkg::BYTE_W]};
              end
              hms_pkg::CMD_START: begin
                s_d.run = 1'b1;
                s_d.brk = 1'b0;
              end
              hms_pkg::CMD_STOP: begin
                s_d.run = 1'b0;
              end
              hms_pkg::CMD_STATUS: begin
                s_d.data = {s_q.data[31:16], status_val};
              end
              hms_pkg::CMD_ESCAPE: begin
                if (s_q.data[15:0] == hms_pkg::ESC_RESET) begin
                  s_d.rst = 1'b1;
                end
              end
              default: begin
                s_d.lit = s_q.lit;
              end
            endcase
          end
        end
        default: begin
          s_d.mode = hms_pkg::HMS_ECHO;
        end
      endcase
    end
  end

  // State register; reset lands in echo mode
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign TX_VALID = s_q.tx_valid;
  assign TX_DATA = s_q.tx_data;
  assign LED_PORT = s_q.led;
  assign RING_IND = s_q.run;
  assign NMI_REQ = RX_VALID;
  assign RESET_REQ = s_q.rst;
  assign USER_MAP = s_q.umap;
  assign PRDATA = rd_data;
  assign PREADY = 1'b1;
  assign PSLVERR = apb_err;

endmodule

// File: verilog/hms_pkg.sv
/*
  Shared constants and carriers for the host monitor command interpreter.
  Assumes a byte-wide received-character strobe from a serial receiver
  and a byte-wide transmit path with a ready handshake.
*/
package hms_pkg;

  // Command codes and character classes
  localparam logic [7:0] CMD_LITERAL = 8'h00;
  localparam logic [7:0] CMD_XMIT = 8'h02;
  localparam logic [7:0] CMD_START = 8'h12;
  localparam logic [7:0] CMD_STOP = 8'h13;
  localparam logic [7:0] CMD_STATUS = 8'h14;
  localparam logic [7:0] CMD_ESCAPE = 8'h15;
  localparam logic [7:0] CMD_LIMIT = 8'h20;
  localparam logic [7:0] CHR_SLASH = 8'h2F;
  localparam logic [7:0] CHR_BSLASH = 8'h5C;
  localparam logic [7:0] ECHO_STEP = 8'h01;

  // Status values and escape sub-function
  localparam logic [15:0] STAT_STOPPED = 16'h0000;
  localparam logic [15:0] STAT_RUNNING = 16'h0001;
  localparam logic [15:0] STAT_BREAK = 16'h0002;
  localparam logic [15:0] ESC_RESET = 16'h0001;
  localparam int BYTE_W = 8;

  // APB register byte offsets
  localparam logic [7:0] REG_DATA = 8'h00;
  localparam logic [7:0] REG_FLAGS = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam logic [7:0] REG_LAST = 8'h0C;

  // Flag bit positions in the flag register
  localparam int FLG_LIT = 0;
  localparam int FLG_BRK = 1;
  localparam int FLG_RUN = 2;
  localparam int FLG_MAP = 3;
  localparam int FLG_ECHO = 4;
  localparam int FLG_DIAG = 7;

  // Control register bits (write-one actions)
  localparam int CTL_BREAK = 0;
  localparam int CTL_STOP = 1;

  typedef enum logic [1:0] {
    HMS_ECHO = 2'b00,
    HMS_NORMAL = 2'b01,
    HMS_DIAG = 2'b10
  } hms_mode_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } hms_apb_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } hms_byte_t;

endpackage
